// ### pkg/tcr_pkg.sv
// Constants, register map and carrier types for the tributary transmit
// configuration register bank.
// Assumes a 32-bit classic Wishbone bus with 8-bit registers in the low lane.
package tcr_pkg;

    // ------------------------------------------------------------------
    // Register map (word indices; byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int         IDX_W          = 9;
    localparam logic [8:0] GLOB_CONF_IDX  = 9'h000;
    localparam logic [8:0] PTR_RST_IDX    = 9'h008;
    localparam logic [8:0] PTR_RST_ALT_IDX = 9'h004;
    localparam logic [8:0] SLOT_BASE_IDX  = 9'h161;
    localparam logic [3:0] OFS_EXP_TRACE  = 4'hc;
    localparam logic [3:0] OFS_ERR_INSERT = 4'hd;
    localparam logic [3:0] OFS_LABEL      = 4'he;
    localparam logic [3:0] OFS_TX_TRACE   = 4'hf;

    // ------------------------------------------------------------------
    // Field positions and writable masks
    // ------------------------------------------------------------------
    localparam int         GC_UNEQ_BIT    = 2;
    localparam int         GC_TERMINAL_OR_ADM_SEL_BIT  = 1;
    localparam int         LBL_RFI_BIT    = 4;
    localparam int         LBL_CODE_LSB   = 1;
    localparam int         ERR_ACCESS_BIT = 6;
    localparam int         ERR_AIS_BIT    = 5;
    localparam int         ERR_RDI_EN_BIT = 4;
    localparam int         ERR_RDI_FRC_BIT = 3;
    localparam int         ERR_REI_EN_BIT = 2;
    localparam int         ERR_REI_FRC_BIT = 1;
    localparam int         ERR_BIP_BIT    = 0;
    localparam logic [7:0] GC_MASK        = 8'h06;
    localparam logic [7:0] SLOT_MASK      = 8'h1f;
    localparam logic [7:0] LBL_MASK       = 8'h1e;
    localparam logic [7:0] ERR_MASK       = 8'h7f;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] GC_RST         = 8'h00;
    localparam logic [7:0] LBL_RST        = 8'h04;
    localparam logic [7:0] ERR_RST        = 8'h54;
    localparam logic [7:0] TRACE_RST      = 8'h00;
    localparam logic [3:0] PTR_RST_VAL    = 4'h0;
    localparam logic [2:0] LABEL_UNEQ     = 3'b000;
    localparam logic [7:0] J2_UNEQ_STD    = 8'h00;
    localparam logic [7:0] J2_UNEQ_SUP    = 8'h01;
    localparam logic [2:0] K4_ERDI_FORCE  = 3'b111;
    localparam logic [2:0] K4_ERDI_IDLE   = 3'b000;
    localparam int         TRACE_LEN      = 16;

    // ------------------------------------------------------------------
    // Per-tributary settings handed to the mapping datapath
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       slot_valid;
        logic [4:0] slot;
        logic [2:0] path_label_code;
        logic       remote_fail_bit;
        logic       unequipped;
        logic       force_tu_alarm_signal;
        logic       auto_rdi_update;
        logic       force_rdi;
        logic [2:0] k4_erdi;
        logic       auto_rei_update;
        logic       force_rei;
        logic       parity_invert;
        logic       trace_ram_cpu_access;
    } tcr_trib_cfg_t;

endpackage : tcr_pkg

// ### rtl/tcr_regs.sv
// Tributary transmit configuration register bank: slot assignment, path
// label, path trace memories with a shared pointer, diagnostic forcing.
// Assumes a classic Wishbone master on sys_clk and a datapath that reads
// the trace memories through the two lookup ports below.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module tcr_regs
    import tcr_pkg::*;
#(
    parameter int NUM_TRIB = 21
) (
    input  wire logic                        sys_clk,
    input  wire logic                        reset_n,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [10:0]                 wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    output logic                             terminal_or_adm_sel,
    output logic                             unequipped_form_sel,
    output tcr_trib_cfg_t [NUM_TRIB-1:0]     trib_cfg,
    input  wire logic [4:0]                  tx_trace_trib,
    input  wire logic [3:0]                  tx_trace_idx,
    output logic      [7:0]                  transmit_trace_byte,
    input  wire logic [4:0]                  exp_trace_trib,
    input  wire logic [3:0]                  exp_trace_idx,
    output logic      [7:0]                  expected_trace_byte
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The page field and the five-bit slot code cap the bank at 21.
    if (NUM_TRIB < 1 || NUM_TRIB > 21) begin : g_bad_num_trib
        $error("NUM_TRIB must lie between 1 and 21");
    end

    localparam int MEM_DEPTH = NUM_TRIB * TRACE_LEN;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic                   ack_r;
    logic [7:0]             glob_r;
    logic [3:0]             ptr_r;
    logic [3:0]             ptr_nxt;
    logic [7:0]             rdata_r;
    logic [7:0]             slot_r [NUM_TRIB];
    logic [7:0]             label_r [NUM_TRIB];
    logic [7:0]             err_r [NUM_TRIB];
    logic [7:0]             exp_mem [MEM_DEPTH];
    logic [7:0]             tx_mem [MEM_DEPTH];
    logic [7:0]             tx_byte_r;
    logic [7:0]             exp_byte_r;
    tcr_trib_cfg_t          cfg_r [NUM_TRIB];

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic [IDX_W-1:0]  idx        = wb_adr_i[10:2];
    wire logic [4:0]        page       = idx[8:4];
    wire logic [3:0]        page_ofs   = idx[3:0];
    wire logic              access     = wb_cyc_i & wb_stb_i & ~ack_r;
    wire logic              wr_lane    = access & wb_we_i & wb_sel_i[0];
    wire logic [7:0]        wdat       = wb_dat_i[7:0];
    wire logic              page_hit   = (page != 5'h00) && (32'(page) <= NUM_TRIB);
    wire logic [4:0]        trib_sel   = page - 5'h01;
    wire logic [IDX_W-1:0]  slot_ofs   = idx - SLOT_BASE_IDX;
    wire logic              slot_hit   = (idx >= SLOT_BASE_IDX) &&
                                         (32'(slot_ofs) < NUM_TRIB);
    wire logic [4:0]        slot_sel   = slot_ofs[4:0];
    wire logic              glob_hit   = (idx == GLOB_CONF_IDX);
    wire logic              prst_hit   = (idx == PTR_RST_IDX) ||
                                         (idx == PTR_RST_ALT_IDX);
    wire logic              exp_hit    = page_hit && (page_ofs == OFS_EXP_TRACE);
    wire logic              err_hit    = page_hit && (page_ofs == OFS_ERR_INSERT);
    wire logic              lbl_hit    = page_hit && (page_ofs == OFS_LABEL);
    wire logic              txt_hit    = page_hit && (page_ofs == OFS_TX_TRACE);
    wire logic [8:0]        mem_adr    = {trib_sel, ptr_r};
    wire logic              tx_open    = err_r[trib_sel][ERR_ACCESS_BIT];
    wire logic              ptr_clear  = access & wb_we_i & prst_hit;
    wire logic              ptr_step   = access & (exp_hit | txt_hit);

    // Pointer wraps naturally at 16, so whole-string transfers realign it.
    assign ptr_nxt = ptr_clear ? PTR_RST_VAL :
                     ptr_step  ? ptr_r + 4'h1 : ptr_r;

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    wire logic [7:0]        rd_glob    = glob_hit ? glob_r : 8'h00;
    wire logic [7:0]        rd_slot    = slot_hit ? slot_r[slot_sel] : 8'h00;
    wire logic [7:0]        rd_lbl     = lbl_hit ? label_r[trib_sel] : 8'h00;
    wire logic [7:0]        rd_err     = err_hit ? err_r[trib_sel] : 8'h00;
    wire logic [7:0]        rd_exp     = exp_hit ? exp_mem[mem_adr] : 8'h00;
    wire logic [7:0]        rd_txt     = (txt_hit && tx_open) ? tx_mem[mem_adr] : 8'h00;
    // Pointer-reset register is write-only and unmapped words read zero.
    wire logic [7:0]        rd_mux     = rd_glob | rd_slot | rd_lbl | rd_err |
                                         rd_exp | rd_txt;

    // ------------------------------------------------------------------
    // Bus handshake and shared pointer
    // ------------------------------------------------------------------
    // One wait state: ack rises the cycle after the request and drops next.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r   <= 1'b0;
            rdata_r <= 8'h00;
            ptr_r   <= PTR_RST_VAL;
        end else begin
            ack_r   <= access;
            rdata_r <= access ? rd_mux : rdata_r;
            ptr_r   <= ptr_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = {24'h000000, rdata_r};

    // ------------------------------------------------------------------
    // Global configuration
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            glob_r <= GC_RST;
        end else if (wr_lane && glob_hit) begin
            glob_r <= wdat & GC_MASK;
        end
    end

    assign terminal_or_adm_sel = glob_r[GC_TERMINAL_OR_ADM_SEL_BIT];
    assign unequipped_form_sel = glob_r[GC_UNEQ_BIT];

    // ------------------------------------------------------------------
    // Per-tributary registers and derived settings
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NUM_TRIB; g++) begin : g_trib
        wire logic        slot_wr  = wr_lane && slot_hit && (slot_sel == 5'(g));
        wire logic        page_wr  = wr_lane && (trib_sel == 5'(g));
        wire logic [4:0]  slot_fld = slot_r[g][4:0];
        wire logic        legal    = (slot_fld != 5'h00) && (slot_fld <= 5'd21);
        wire logic [2:0]  code     = label_r[g][LBL_CODE_LSB +: 3];
        wire logic        rdi_frc  = err_r[g][ERR_RDI_FRC_BIT];
        tcr_trib_cfg_t    cfg_nxt;

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                slot_r[g]  <= 8'(g + 1);
                label_r[g] <= LBL_RST;
                err_r[g]   <= ERR_RST;
            end else begin
                if (slot_wr) begin
                    slot_r[g] <= wdat & SLOT_MASK;
                end
                if (page_wr && lbl_hit) begin
                    label_r[g] <= wdat & LBL_MASK;
                end
                if (page_wr && err_hit) begin
                    err_r[g] <= wdat & ERR_MASK;
                end
            end
        end

        // Terminal mode keeps the fixed port-to-slot mapping.
        always_comb begin
            cfg_nxt                       = '0;
            cfg_nxt.slot_valid            = !terminal_or_adm_sel || legal;
            cfg_nxt.slot                  = terminal_or_adm_sel ? slot_fld : 5'(g + 1);
            cfg_nxt.path_label_code       = code;
            cfg_nxt.remote_fail_bit       = label_r[g][LBL_RFI_BIT];
            cfg_nxt.unequipped            = (code == LABEL_UNEQ);
            cfg_nxt.force_tu_alarm_signal = err_r[g][ERR_AIS_BIT];
            cfg_nxt.auto_rdi_update       = err_r[g][ERR_RDI_EN_BIT];
            cfg_nxt.force_rdi             = rdi_frc;
            cfg_nxt.k4_erdi               = rdi_frc ? K4_ERDI_FORCE : K4_ERDI_IDLE;
            cfg_nxt.auto_rei_update       = err_r[g][ERR_REI_EN_BIT];
            cfg_nxt.force_rei             = err_r[g][ERR_REI_FRC_BIT];
            cfg_nxt.parity_invert         = err_r[g][ERR_BIP_BIT];
            cfg_nxt.trace_ram_cpu_access  = err_r[g][ERR_ACCESS_BIT];
        end

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                cfg_r[g] <= '0;
            end else begin
                cfg_r[g] <= cfg_nxt;
            end
        end

        assign trib_cfg[g] = cfg_r[g];
    end

    // ------------------------------------------------------------------
    // Path trace memories
    // ------------------------------------------------------------------
    // Flop-based so both strings reset to zero; small enough at 672 bytes.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                exp_mem[i] <= TRACE_RST;
                tx_mem[i]  <= TRACE_RST;
            end
        end else begin
            if (wr_lane && exp_hit) begin
                exp_mem[mem_adr] <= wdat;
            end
            if (wr_lane && txt_hit && tx_open) begin
                tx_mem[mem_adr] <= wdat;
            end
        end
    end

    // ------------------------------------------------------------------
    // Datapath lookup ports
    // ------------------------------------------------------------------
    wire logic        tx_lk_ok   = 32'(tx_trace_trib) < NUM_TRIB;
    wire logic        exp_lk_ok  = 32'(exp_trace_trib) < NUM_TRIB;
    wire logic [8:0]  tx_lk_adr  = {tx_trace_trib, tx_trace_idx};
    wire logic [8:0]  exp_lk_adr = {exp_trace_trib, exp_trace_idx};
    wire logic        tx_lk_cpu  = tx_lk_ok && err_r[tx_trace_trib][ERR_ACCESS_BIT];
    // While software owns the string the line carries a fixed byte.
    wire logic [7:0]  uneq_byte  = unequipped_form_sel ? J2_UNEQ_SUP : J2_UNEQ_STD;
    wire logic [7:0]  tx_lk_byte = tx_lk_cpu ? uneq_byte :
                                   tx_lk_ok  ? tx_mem[tx_lk_adr] : 8'h00;
    wire logic [7:0]  exp_lk_byte = exp_lk_ok ? exp_mem[exp_lk_adr] : 8'h00;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_byte_r  <= 8'h00;
            exp_byte_r <= 8'h00;
        end else begin
            tx_byte_r  <= tx_lk_byte;
            exp_byte_r <= exp_lk_byte;
        end
    end

    assign transmit_trace_byte = tx_byte_r;
    assign expected_trace_byte = exp_byte_r;

endmodule : tcr_regs

`default_nettype wire

// ### sim/tcr_regs_sva.sv
// Concurrent checks on the tributary configuration bank's ports.
// Assumes it is bound to tcr_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tcr_regs_sva
    import tcr_pkg::*;
#(
    parameter int NUM_TRIB = 21
) (
    input wire logic                        sys_clk,
    input wire logic                        reset_n,
    input wire logic                        wb_cyc_i,
    input wire logic                        wb_stb_i,
    input wire logic                        wb_we_i,
    input wire logic [10:0]                 wb_adr_i,
    input wire logic [3:0]                  wb_sel_i,
    input wire logic [31:0]                 wb_dat_i,
    input wire logic                        wb_ack_o,
    input wire logic                        terminal_or_adm_sel,
    input wire logic                        unequipped_form_sel,
    input wire tcr_trib_cfg_t [NUM_TRIB-1:0] trib_cfg,
    input wire logic [4:0]                  tx_trace_trib,
    input wire logic [7:0]                  transmit_trace_byte
);
    // ------------------------------------------------------------------
    // Decode of taken writes; only global writes and tributary 1 label and error insert writes are decoded to keep it small
    // ------------------------------------------------------------------
    wire           taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [8:0]     idx   = wb_adr_i[10:2];
    wire           wr    = taken & wb_we_i & wb_sel_i[0];
    wire           glob  = wr & (idx == GLOB_CONF_IDX);
    wire           lbl1  = wr & (idx == {5'h01, OFS_LABEL});
    wire           err1  = wr & (idx == {5'h01, OFS_ERR_INSERT});
    wire tcr_trib_cfg_t c0 = trib_cfg[0];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    AST_ACK_LATENCY: assert property (taken |=> wb_ack_o)
        else $error("ack missing one cycle after a request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    AST_GLOBAL_BITS: assert property (glob |=> unequipped_form_sel == $past(wb_dat_i[2])
        && terminal_or_adm_sel == $past(wb_dat_i[1])) else $error("global bits not stored");
    AST_LABEL_FIELDS: assert property (lbl1 |=> ##1
        {c0.remote_fail_bit, c0.path_label_code} == $past(wb_dat_i[4:1], 2))
        else $error("label fields do not follow the written value");
    AST_ERR_FIELDS: assert property (err1 |=> ##1 {c0.trace_ram_cpu_access,
        c0.force_tu_alarm_signal, c0.auto_rdi_update, c0.force_rdi, c0.auto_rei_update,
        c0.force_rei, c0.parity_invert} == $past(wb_dat_i[6:0], 2))
        else $error("error insert controls do not follow the written value");
    AST_UNEQ_LABEL: assert property ($past(reset_n) |->
        c0.unequipped == (c0.path_label_code == LABEL_UNEQ)) else $error("unequipped flag wrong");
    AST_K4_FORCE: assert property ($past(reset_n) |->
        c0.k4_erdi == (c0.force_rdi ? K4_ERDI_FORCE : K4_ERDI_IDLE)) else $error("k4 bits wrong");
    AST_TRACE_FORCE: assert property ((tx_trace_trib == 5'h00) ##1
        c0.trace_ram_cpu_access |-> transmit_trace_byte ==
        ($past(unequipped_form_sel) ? J2_UNEQ_SUP : J2_UNEQ_STD))
        else $error("trace byte not forced while access enabled");
    AST_SLOT_TERMINAL: assert property (reset_n && !terminal_or_adm_sel
        ##1 !terminal_or_adm_sel |-> trib_cfg[NUM_TRIB-1].slot_valid
        && trib_cfg[NUM_TRIB-1].slot == 5'(NUM_TRIB))
        else $error("terminal mode slot not the port number");
endmodule : tcr_regs_sva

bind tcr_regs tcr_regs_sva #(.NUM_TRIB(NUM_TRIB)) u_sva (.sys_clk(sys_clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .terminal_or_adm_sel(terminal_or_adm_sel), .unequipped_form_sel(unequipped_form_sel),
    .trib_cfg(trib_cfg), .tx_trace_trib(tx_trace_trib), .transmit_trace_byte(transmit_trace_byte));
`default_nettype wire

// ### sim/tcr_regs_tb_top.sv
// Self-checking bench for the tributary configuration bank against a model.
// Assumes a one-wait-state classic Wishbone slave and one-cycle lookups.
`timescale 1ns/1ps
`default_nettype none
module tcr_regs_tb_top
    import tcr_pkg::*;
;
    logic                 sys_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [10:0]          wb_adr_i;
    logic [3:0]           wb_sel_i;
    logic [31:0]          wb_dat_i, wb_dat_o;
    logic                 terminal_or_adm_sel, unequipped_form_sel;
    tcr_trib_cfg_t [20:0] trib_cfg;
    logic [4:0]           tx_trace_trib, exp_trace_trib;
    logic [3:0]           tx_trace_idx, exp_trace_idx;
    logic [7:0]           transmit_trace_byte, expected_trace_byte;
    int                   error_cnt = 0;
    int                   compares  = 0;
    logic [7:0]           m_gc, m_slot[21], m_lbl[21], m_err[21], m_exp[21][16], m_tx[21][16];
    int                   m_ptr;

    tcr_regs #(.NUM_TRIB(21)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .terminal_or_adm_sel(terminal_or_adm_sel), .unequipped_form_sel(unequipped_form_sel),
        .trib_cfg(trib_cfg), .tx_trace_trib(tx_trace_trib), .tx_trace_idx(tx_trace_idx),
        .transmit_trace_byte(transmit_trace_byte), .exp_trace_trib(exp_trace_trib),
        .exp_trace_idx(exp_trace_idx), .expected_trace_byte(expected_trace_byte));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------------
    // Compare, bus and model tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    function automatic tcr_trib_cfg_t exp_cfg(input int t);
        tcr_trib_cfg_t c;
        c.slot_valid = m_gc[1] ? (m_slot[t] inside {[1:21]}) : 1'b1;
        c.slot = m_gc[1] ? m_slot[t][4:0] : 5'(t + 1);
        {c.remote_fail_bit, c.path_label_code} = m_lbl[t][4:1];
        c.unequipped = (m_lbl[t][3:1] == 3'b000);
        {c.trace_ram_cpu_access, c.force_tu_alarm_signal, c.auto_rdi_update, c.force_rdi,
            c.auto_rei_update, c.force_rei, c.parity_invert} = m_err[t][6:0];
        c.k4_erdi = {3{m_err[t][3]}};
        return c;
    endfunction : exp_cfg

    task automatic check_cfg();
        @(posedge sys_clk);
        check({30'h0, unequipped_form_sel, terminal_or_adm_sel}, {30'h0, m_gc[2:1]}, "globals");
        for (int t = 0; t < 21; t++) begin
            compares++;
            if (trib_cfg[t] !== exp_cfg(t)) begin
                error_cnt++;
                $display("mismatch at %0t: settings of tributary %0d", $time, t + 1);
            end
        end
    endtask : check_cfg

    task automatic acc(input logic we, input logic [8:0] idx, input logic [7:0] d);
        int          n;
        int          t;
        logic [7:0]  e;
        t = int'(idx[8:4]) - 1;
        e = 8'h00;
        if (idx == GLOB_CONF_IDX) begin
            e = m_gc;
            if (we) m_gc = d & GC_MASK;
        end else if (idx == PTR_RST_IDX || idx == PTR_RST_ALT_IDX) begin
            if (we) m_ptr = 0;
        end else if (idx > 9'h160 && idx < 9'h176) begin
            e = m_slot[idx - SLOT_BASE_IDX];
            if (we) m_slot[idx - SLOT_BASE_IDX] = d & SLOT_MASK;
        end else if (t >= 0 && t < 21) begin
            case (idx[3:0])
                OFS_EXP_TRACE: begin
                    e = m_exp[t][m_ptr];
                    if (we) m_exp[t][m_ptr] = d;
                    m_ptr = (m_ptr + 1) % 16;
                end
                OFS_TX_TRACE: begin
                    e = m_err[t][6] ? m_tx[t][m_ptr] : 8'h00;
                    if (we && m_err[t][6]) m_tx[t][m_ptr] = d;
                    m_ptr = (m_ptr + 1) % 16;
                end
                OFS_ERR_INSERT: begin
                    e = m_err[t];
                    if (we) m_err[t] = d & ERR_MASK;
                end
                OFS_LABEL: begin
                    e = m_lbl[t];
                    if (we) m_lbl[t] = d & LBL_MASK;
                end
                default: e = 8'h00;
            endcase
        end
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hf;
        wb_dat_i <= {24'($urandom), d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        check({31'h0, wb_ack_o}, 32'h1, "ack");
        if (!we) check(wb_dat_o, {24'h0, e}, "read");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : acc

    task automatic look(input int t, input int i);
        @(posedge sys_clk);
        tx_trace_trib  <= 5'(t);
        tx_trace_idx   <= 4'(i);
        exp_trace_trib <= 5'(t);
        exp_trace_idx  <= 4'(i);
        repeat (2) @(posedge sys_clk);
        check({24'h0, transmit_trace_byte}, {24'h0, m_err[t][6] ? {7'h0, m_gc[2]} : m_tx[t][i]},
            "tx lookup");
        check({24'h0, expected_trace_byte}, {24'h0, m_exp[t][i]}, "exp lookup");
    endtask : look

    task automatic end_sim();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    initial begin
        #50000;
        error_cnt++;
        end_sim();
    end
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [8:0] idx;
        logic [7:0] d;
        logic [4:0] sv [5];
        int         a, b;
        sv = '{5'h00, 5'h01, 5'h15, 5'h16, 5'h1f};
        {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {tx_trace_trib, tx_trace_idx, exp_trace_trib, exp_trace_idx} = '0;
        void'($urandom(32'ha9838dbb));
        m_gc = GC_RST;
        m_ptr = 0;
        for (int t = 0; t < 21; t++) begin
            m_slot[t] = 8'(t + 1);
            m_lbl[t] = LBL_RST;
            m_err[t] = ERR_RST;
            for (int i = 0; i < 16; i++) {m_exp[t][i], m_tx[t][i]} = {TRACE_RST, TRACE_RST};
        end
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 9'h160; i < 9'h177; i++) acc(1'b0, 9'(i), 8'h00);
        acc(1'b0, GLOB_CONF_IDX, 8'h00);
        acc(1'b0, PTR_RST_IDX, 8'h00);
        for (int t = 1; t < 22; t++) acc(1'b0, {5'(t), OFS_ERR_INSERT}, 8'h00);
        for (int t = 1; t < 22; t++) acc(1'b0, {5'(t), OFS_LABEL}, 8'h00);
        check_cfg();
        $display("test reset values done");
        for (int m = 0; m < 4; m++) begin
            acc(1'b1, GLOB_CONF_IDX, 8'h02 | 8'(m << 2));
            for (int k = 0; k < 5; k++) begin
                idx = SLOT_BASE_IDX + 9'($urandom_range(20));
                acc(1'b1, idx, {3'($urandom), sv[k]});
                acc(1'b0, idx, 8'h00);
            end
            acc(1'b1, GLOB_CONF_IDX, (8'($urandom) & 8'hf9) | 8'(m << 1));
            for (int c = 0; c < 3; c++) begin
                idx = {5'(c == 0 ? 1 : $urandom_range(1, 21)), OFS_LABEL};
                d = 8'($urandom);
                d[3:1] = 3'(c);
                acc(1'b1, idx, d);
                acc(1'b0, idx, 8'h00);
                check_cfg();
            end
        end
        $display("test modes and labels done");
        for (int k = 0; k < 8; k++) begin
            idx = {5'(k % 2 ? $urandom_range(1, 21) : 1), OFS_ERR_INSERT};
            acc(1'b1, idx, 8'(1 << k));
            acc(1'b0, idx, 8'h00);
            check_cfg();
            acc(1'b1, idx, ERR_RST);
        end
        $display("test error insert done");
        a = $urandom_range(1, 21);
        b = a % 21 + 1;
        acc(1'b1, PTR_RST_IDX, 8'($urandom));
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 16; i++) acc(1'b1, {5'(a), OFS_EXP_TRACE}, 8'($urandom));
        for (int i = 0; i < 16; i++) acc(1'b1, {5'(b), OFS_TX_TRACE}, 8'($urandom));
        for (int i = 0; i < 16; i++) acc(1'b0, {5'(a), OFS_EXP_TRACE}, 8'h00);
        for (int i = 0; i < 5; i++) acc(1'b0, {5'(b), OFS_TX_TRACE}, 8'h00);
        acc(1'b1, PTR_RST_ALT_IDX, 8'($urandom));
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 16; i++) acc(1'b0, {5'(b), OFS_TX_TRACE}, 8'h00);
        acc(1'b1, {5'(b), OFS_ERR_INSERT}, ERR_RST & 8'hbf);
        for (int i = 0; i < 3; i++) acc(1'b1, {5'(b), OFS_TX_TRACE}, 8'($urandom));
        for (int i = 0; i < 16; i++) acc(1'b0, {5'(a), OFS_EXP_TRACE}, 8'h00);
        for (int g = 0; g < 2; g++) begin
            acc(1'b1, GLOB_CONF_IDX, 8'(g << 2));
            for (int i = 0; i < 16; i++) look(a - 1, i);
            for (int i = 0; i < 16; i++) look(b - 1, i);
            look(0, g);
        end
        $display("test trace memories done");
        end_sim();
    end
endmodule : tcr_regs_tb_top
`default_nettype wire
